// [hw/rsl_rail_enable.sv]
// What this block does
// - two-bit field picks switch A1 good threshold: 1.5, 1.8, 2.5, 3.3 V.
// - three-bit field picks switch A1 enable source; six codes pick one control input.
// - source code 101 enables from control inputs 3 and 4 together.
// - source code 111 feeds a constant one; no pin needed.
// - bit 1 set masks the B2/A1 pair good from switch A1 enable.
// - bit 0 set masks switch B1 good from switch A1 enable.
// - termination enable follows input 3, or input 6 when bit 6 set.
// - bits 5:3 choose falling-edge delay, none up to 64 ms.
// - bits 2:0 choose rising-edge delay with the same code.
// - delays may deviate ten percent from nominal.
// - A2 mask bit 7 set masks regulator A3 good from A2 logic.
// - A2 mask bit 6 set masks switch A1 good from A2 logic.
// - A2 mask bits 5:0 mask step-down rails 6..1 goods.
`default_nettype none
module rsl_rail_enable
  import rsl_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [5:0]  CONTROL_INPUT_IN,
  input  wire logic        LOAD_SWITCH_B1_GOOD_IN,
  input  wire logic        PAIR_GOOD_IN,
  input  wire logic        LOAD_SWITCH_A1_GOOD_IN,
  input  wire logic        REGULATOR_A3_GOOD_IN,
  input  wire logic [5:0]  STEP_DOWN_GOOD_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic [7:0]       REG_RDATA_OUT,
  output logic             LOAD_SWITCH_A1_ENABLE_OUT,
  output logic [1:0]       SWITCH_A1_THRESHOLD_OUT,
  output logic [11:0]      SWITCH_A1_THRESHOLD_MV_OUT,
  output logic             TERMINATION_ENABLE_OUT,
  output logic             REGULATOR_A2_GOODS_OK_OUT
);
  if (CYC_PER_MS_P < 1 || CYC_PER_MS_P > 65535) begin : g_bad_rate
    $error("rsl_rail_enable: cycles per ms out of range");
  end

  logic [7:0]  src_ctrl_reg, src_ctrl_next;
  logic [7:0]  dly_ctrl_reg, dly_ctrl_next;
  logic [7:0]  a2_mask_reg,  a2_mask_next;
  logic [7:0]  rdata_reg,    rdata_next;
  logic        term_reg,     term_next;
  logic        a2_ok_reg,    a2_ok_next;
  logic        source_level;
  logic        a1_goods_ok;
  logic [7:0]  a2_goods;
  logic [1:0]  thr_code;
  rsl_src_t    src_sel;

  function automatic logic [7:0] rsl_read(
    input logic [7:0] addr,
    input logic [7:0] src,
    input logic [7:0] dlyv,
    input logic [7:0] mask
  );
    unique case (addr)
      SRC_CTRL_OFFSET: rsl_read = src & SRC_CTRL_WMASK;
      DLY_CTRL_OFFSET: rsl_read = dlyv & DLY_CTRL_WMASK;
      A2_MASK_OFFSET:  rsl_read = mask & A2_MASK_WMASK;
      default:         rsl_read = 8'h00;
    endcase
  endfunction

  // register file: writes land at once, reads return one cycle later
  always_comb begin
    src_ctrl_next = src_ctrl_reg;
    dly_ctrl_next = dly_ctrl_reg;
    a2_mask_next  = a2_mask_reg;
    rdata_next    = rdata_reg;
    if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        SRC_CTRL_OFFSET: src_ctrl_next = REG_WDATA_IN & SRC_CTRL_WMASK;
        DLY_CTRL_OFFSET: dly_ctrl_next = REG_WDATA_IN & DLY_CTRL_WMASK;
        A2_MASK_OFFSET:  a2_mask_next  = REG_WDATA_IN & A2_MASK_WMASK;
        default: ;
      endcase
    end
    if (REG_RD_IN) begin
      rdata_next = rsl_read(REG_ADDR_IN, src_ctrl_reg, dly_ctrl_reg,
                            a2_mask_reg);
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      src_ctrl_reg <= SRC_CTRL_RESET;
      dly_ctrl_reg <= DLY_CTRL_RESET;
      a2_mask_reg  <= A2_MASK_RESET;
      rdata_reg    <= 8'h00;
    end else begin
      src_ctrl_reg <= src_ctrl_next;
      dly_ctrl_reg <= dly_ctrl_next;
      a2_mask_reg  <= a2_mask_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign src_sel  = rsl_src_t'(src_ctrl_reg[SRC_LSB +: 3]);
  assign thr_code = src_ctrl_reg[THR_LSB +: 2];

  // the input numbering of the source code is not in order; keep as is
  always_comb begin
    unique case (src_sel)
      SRC_IN1:   source_level = CONTROL_INPUT_IN[0];
      SRC_IN2:   source_level = CONTROL_INPUT_IN[1];
      SRC_IN5:   source_level = CONTROL_INPUT_IN[4];
      SRC_IN4:   source_level = CONTROL_INPUT_IN[3];
      SRC_IN3:   source_level = CONTROL_INPUT_IN[2];
      SRC_IN3_4: source_level = CONTROL_INPUT_IN[2]
                              & CONTROL_INPUT_IN[3];
      SRC_IN6:   source_level = CONTROL_INPUT_IN[5];
      SRC_ONE:   source_level = 1'b1;
    endcase
  end

  assign a1_goods_ok =
      (src_ctrl_reg[PAIR_MASK_BIT] | PAIR_GOOD_IN)
    & (src_ctrl_reg[B1_MASK_BIT] | LOAD_SWITCH_B1_GOOD_IN);

  assign a2_goods = {REGULATOR_A3_GOOD_IN, LOAD_SWITCH_A1_GOOD_IN,
                     STEP_DOWN_GOOD_IN};

  // a masked good counts as good, so an all-ones mask always passes
  always_comb begin
    a2_ok_next = &(a2_mask_reg | a2_goods);
    term_next  = dly_ctrl_reg[TERM_SEL_BIT] ? CONTROL_INPUT_IN[5]
                                            : CONTROL_INPUT_IN[2];
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      term_reg  <= 1'b0;
      a2_ok_reg <= 1'b0;
    end else begin
      term_reg  <= term_next;
      a2_ok_reg <= a2_ok_next;
    end
  end

  rsl_delay_if a1_dly ();
  assign a1_dly.req      = source_level & a1_goods_ok;
  assign a1_dly.on_code  = dly_ctrl_reg[ON_DLY_LSB +: 3];
  assign a1_dly.off_code = dly_ctrl_reg[OFF_DLY_LSB +: 3];

  rsl_edge_timer #(
    .CYC_PER_MS_P (CYC_PER_MS_P)
  ) u_a1_timer (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .dly    (a1_dly.timer)
  );

  assign REG_RDATA_OUT              = rdata_reg;
  assign LOAD_SWITCH_A1_ENABLE_OUT  = a1_dly.en;
  assign SWITCH_A1_THRESHOLD_OUT    = thr_code;
  assign SWITCH_A1_THRESHOLD_MV_OUT = rsl_thr_mv(thr_code);
  assign TERMINATION_ENABLE_OUT     = term_reg;
  assign REGULATOR_A2_GOODS_OK_OUT  = a2_ok_reg;

  chk_threshold_map:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (thr_code == THR_1V5) == (SWITCH_A1_THRESHOLD_MV_OUT == THR_1V5_MV)
      && (thr_code == THR_3V3) == (SWITCH_A1_THRESHOLD_MV_OUT == THR_3V3_MV))
    else $error("threshold does not follow its field");
  chk_in6_source:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      src_sel == SRC_IN6 && !CONTROL_INPUT_IN[5] |-> !a1_dly.req)
    else $error("input six source enabled while low");
  chk_const_source:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      src_sel == SRC_ONE && a1_goods_ok |-> a1_dly.req)
    else $error("constant source did not request enable");
  chk_pair_source:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      src_sel == SRC_IN3_4 && !(CONTROL_INPUT_IN[2] && CONTROL_INPUT_IN[3])
      |-> !a1_dly.req)
    else $error("combined source enabled without both inputs");
  chk_pair_mask:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !src_ctrl_reg[PAIR_MASK_BIT] && !PAIR_GOOD_IN |-> !a1_dly.req)
    else $error("unmasked pair good ignored");
  chk_b1_mask:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !src_ctrl_reg[B1_MASK_BIT] && !LOAD_SWITCH_B1_GOOD_IN
      |-> !a1_dly.req)
    else $error("unmasked B1 good ignored");
  chk_term_select:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      ##1 TERMINATION_ENABLE_OUT == ($past(dly_ctrl_reg[TERM_SEL_BIT])
        ? $past(CONTROL_INPUT_IN[5]) : $past(CONTROL_INPUT_IN[2])))
    else $error("termination enable from wrong input");
  chk_a2_goods:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (a2_mask_reg | a2_goods) != 8'hff |=> !REGULATOR_A2_GOODS_OK_OUT)
    else $error("A2 passed with an unmasked bad good");
  chk_a2_all_masked:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      a2_mask_reg == 8'hff |=> REGULATOR_A2_GOODS_OK_OUT)
    else $error("fully masked A2 goods still block");
  chk_a2_a3_mask:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      a2_mask_reg[A2_A3_BIT] && a2_mask_reg[A2_SWITCH_BIT]
      && (&(a2_mask_reg[5:0] | STEP_DOWN_GOOD_IN))
      |=> REGULATOR_A2_GOODS_OK_OUT)
    else $error("masked goods still block A2");
  chk_enable_gate:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      $rose(LOAD_SWITCH_A1_ENABLE_OUT) |-> $past(a1_dly.req))
    else $error("switch enabled without a request");
  cov_a1_on: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(LOAD_SWITCH_A1_ENABLE_OUT));
  cov_term_six: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    dly_ctrl_reg[TERM_SEL_BIT] && TERMINATION_ENABLE_OUT);
endmodule // rsl_rail_enable
`default_nettype wire

// [hw/rsl_pkg.sv]
`default_nettype none
package rsl_pkg;
  // register offsets
  localparam logic [7:0] SRC_CTRL_OFFSET = 8'h1a;
  localparam logic [7:0] DLY_CTRL_OFFSET = 8'h1b;
  localparam logic [7:0] A2_MASK_OFFSET  = 8'h1c;
  // reset values; the real values arrive from one-time memory
  localparam logic [7:0] SRC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DLY_CTRL_RESET = 8'h00;
  localparam logic [7:0] A2_MASK_RESET  = 8'h00;
  // writable bits; the rest read as zero
  localparam logic [7:0] SRC_CTRL_WMASK = 8'h7f;
  localparam logic [7:0] DLY_CTRL_WMASK = 8'h7f;
  localparam logic [7:0] A2_MASK_WMASK  = 8'hff;
  // field positions
  localparam int THR_LSB        = 5;
  localparam int SRC_LSB        = 2;
  localparam int PAIR_MASK_BIT  = 1;
  localparam int B1_MASK_BIT    = 0;
  localparam int TERM_SEL_BIT   = 6;
  localparam int OFF_DLY_LSB    = 3;
  localparam int ON_DLY_LSB     = 0;
  localparam int A2_A3_BIT      = 7;
  localparam int A2_SWITCH_BIT  = 6;
  localparam int A2_RAIL_LSB    = 0;
  localparam int RAIL_COUNT     = 6;
  // timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int CYC_PER_MS     = CLK_HZ / MS_PER_S;
  localparam logic [6:0] DLY_NONE_MS = 7'h00;
  localparam logic [6:0] DLY_2_MS    = 7'h02;
  localparam logic [6:0] DLY_4_MS    = 7'h04;
  localparam logic [6:0] DLY_8_MS    = 7'h08;
  localparam logic [6:0] DLY_16_MS   = 7'h10;
  localparam logic [6:0] DLY_24_MS   = 7'h18;
  localparam logic [6:0] DLY_32_MS   = 7'h20;
  localparam logic [6:0] DLY_64_MS   = 7'h40;
  // power-good thresholds in millivolts
  localparam logic [11:0] THR_1V5_MV = 12'h5dc;
  localparam logic [11:0] THR_1V8_MV = 12'h708;
  localparam logic [11:0] THR_2V5_MV = 12'h9c4;
  localparam logic [11:0] THR_3V3_MV = 12'hce4;

  typedef enum logic [2:0] {
    SRC_IN1   = 3'h0,
    SRC_IN2   = 3'h1,
    SRC_IN5   = 3'h2,
    SRC_IN4   = 3'h3,
    SRC_IN3   = 3'h4,
    SRC_IN3_4 = 3'h5,
    SRC_IN6   = 3'h6,
    SRC_ONE   = 3'h7
  } rsl_src_t;

  typedef enum logic [1:0] {
    THR_1V5 = 2'h0,
    THR_1V8 = 2'h1,
    THR_2V5 = 2'h2,
    THR_3V3 = 2'h3
  } rsl_thr_t;

  function automatic logic [6:0] rsl_delay_ms(input logic [2:0] code);
    unique case (code)
      3'h0: rsl_delay_ms = DLY_NONE_MS;
      3'h1: rsl_delay_ms = DLY_2_MS;
      3'h2: rsl_delay_ms = DLY_4_MS;
      3'h3: rsl_delay_ms = DLY_8_MS;
      3'h4: rsl_delay_ms = DLY_16_MS;
      3'h5: rsl_delay_ms = DLY_24_MS;
      3'h6: rsl_delay_ms = DLY_32_MS;
      3'h7: rsl_delay_ms = DLY_64_MS;
    endcase
  endfunction

  function automatic logic [11:0] rsl_thr_mv(input logic [1:0] code);
    unique case (code)
      THR_1V5: rsl_thr_mv = THR_1V5_MV;
      THR_1V8: rsl_thr_mv = THR_1V8_MV;
      THR_2V5: rsl_thr_mv = THR_2V5_MV;
      THR_3V3: rsl_thr_mv = THR_3V3_MV;
    endcase
  endfunction
endpackage
`default_nettype wire

// [hw/rsl_delay_if.sv]
`default_nettype none
interface rsl_delay_if;
  logic       req;
  logic [2:0] on_code;
  logic [2:0] off_code;
  logic       en;
  modport ctrl  (output req, output on_code, output off_code, input en);
  modport timer (input req, input on_code, input off_code, output en);
endinterface
`default_nettype wire

// [hw/rsl_edge_timer.sv]
`default_nettype none
module rsl_edge_timer
  import rsl_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  rsl_delay_if.timer  dly
);
  // the prescaler is 16 bits wide, so a faster clock (over 65535 cycles per ms) cannot be served
  if (CYC_PER_MS_P < 1 || CYC_PER_MS_P > 65535) begin : g_bad_rate
    $error("rsl_edge_timer: cycles per ms out of range");
  end

  typedef enum logic [1:0] {
    TMR_IDLE     = 2'b00,
    TMR_WAIT_ON  = 2'b01,
    TMR_WAIT_OFF = 2'b10
  } rsl_tmr_t;

  localparam logic [15:0] PRE_LAST = 16'(CYC_PER_MS_P - 1);

  rsl_tmr_t    state_reg, state_next;
  logic [15:0] pre_reg,   pre_next;
  logic [6:0]  ms_reg,    ms_next;
  logic        en_reg,    en_next;
  logic [6:0]  target_ms;

  // the prescaler restarts on every edge so a delay is whole milliseconds
  always_comb begin
    state_next = state_reg;
    pre_next   = pre_reg;
    ms_next    = ms_reg;
    en_next    = en_reg;
    // nominal delay, exact; the allowed ten percent spread is never used
    target_ms  = rsl_delay_ms(dly.req ? dly.on_code
                                      : dly.off_code);
    unique case (state_reg)
      TMR_IDLE: begin
        if (dly.req != en_reg) begin
          if (target_ms == DLY_NONE_MS) begin
            en_next = dly.req;
          end else begin
            state_next = dly.req ? TMR_WAIT_ON : TMR_WAIT_OFF;
            pre_next   = 16'h0000;
            ms_next    = 7'h00;
          end
        end
      end
      TMR_WAIT_ON, TMR_WAIT_OFF: begin
        if (dly.req == en_reg) begin
          state_next = TMR_IDLE;
        end else if (pre_reg == PRE_LAST) begin
          pre_next = 16'h0000;
          if (ms_reg + 7'h01 >= target_ms) begin
            en_next    = dly.req;
            state_next = TMR_IDLE;
          end else begin
            ms_next = ms_reg + 7'h01;
          end
        end else begin
          pre_next = pre_reg + 16'h0001;
        end
      end
      default: state_next = TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= TMR_IDLE;
      pre_reg   <= 16'h0000;
      ms_reg    <= 7'h00;
      en_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      pre_reg   <= pre_next;
      ms_reg    <= ms_next;
      en_reg    <= en_next;
    end
  end

  assign dly.en = en_reg;

  chk_zero_delay_edge:
    assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg == TMR_IDLE && dly.req != en_reg && target_ms == DLY_NONE_MS
      |=> en_reg == $past(dly.req))
    else $error("zero delay edge not passed through");
  chk_no_early_change:
    assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(en_reg) |-> $past(state_reg) == TMR_IDLE
        || $past(pre_reg) == PRE_LAST)
    else $error("enable changed inside a millisecond");
  chk_cancel_pending:
    assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg != TMR_IDLE && dly.req == en_reg
      |=> state_reg == TMR_IDLE && $stable(en_reg))
    else $error("pending delay not cancelled");
  // a cancelled wait switches the target to the other field; skip that cycle
  chk_ms_bound:
    assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg != TMR_IDLE && dly.req != en_reg |-> ms_reg < target_ms)
    else $error("millisecond count past target");
  cov_wait_on: cover property (@(posedge clk_in) disable iff (rst_in)
    state_reg == TMR_WAIT_ON ##1 $rose(en_reg));
  cov_wait_off: cover property (@(posedge clk_in) disable iff (rst_in)
    state_reg == TMR_WAIT_OFF ##1 $fell(en_reg));
  cov_cancel: cover property (@(posedge clk_in) disable iff (rst_in)
    state_reg != TMR_IDLE && dly.req == en_reg);
endmodule // rsl_edge_timer
`default_nettype wire

// [testbench/rsl_host_model.sv]
`default_nettype none
module rsl_host_model (
  input  wire logic       clk_in,
  output logic      [5:0] ctrl_out,
  output logic            b1_good_out,
  output logic            pair_good_out,
  output logic            a1_good_out,
  output logic            a3_good_out,
  output logic      [5:0] step_good_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // goods are packed {a3, a1, pair, b1, step[5:0]}; all good from the start
  initial begin
    ctrl_out = 6'h00;
    {a3_good_out, a1_good_out, pair_good_out, b1_good_out,
     step_good_out} = 10'h3ff;
  end
  // pins only move on the falling edge, so the block never sees a race
  task automatic set_ctrl(input logic [5:0] v);
    @(negedge clk_in);
    ctrl_out = v;
  endtask
  task automatic set_goods(input logic [9:0] v);
    @(negedge clk_in);
    {a3_good_out, a1_good_out, pair_good_out, b1_good_out,
     step_good_out} = v;
  endtask
endmodule // rsl_host_model
`default_nettype wire

// [testbench/rsl_rail_enable_tb.sv]
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module rsl_rail_enable_tb import rsl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 4;
  logic        clk;
  logic        rst;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        en;
  logic [1:0]  thr;
  logic [11:0] thr_mv;
  logic        term;
  logic        a2ok;
  logic [5:0]  ctrl;
  logic        b1_good;
  logic        pair_good;
  logic        a1_good;
  logic        a3_good;
  logic [5:0]  step_good;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;

  rsl_host_model u_rsl_host_model (
    .clk_in        (clk),
    .ctrl_out      (ctrl),
    .b1_good_out   (b1_good),
    .pair_good_out (pair_good),
    .a1_good_out   (a1_good),
    .a3_good_out   (a3_good),
    .step_good_out (step_good)
  );
  rsl_rail_enable #(
    .CYC_PER_MS_P (CYC)
  ) u_rsl_rail_enable (
    .CLK_IN                     (clk),
    .RST_IN                     (rst),
    .CONTROL_INPUT_IN           (ctrl),
    .LOAD_SWITCH_B1_GOOD_IN     (b1_good),
    .PAIR_GOOD_IN               (pair_good),
    .LOAD_SWITCH_A1_GOOD_IN     (a1_good),
    .REGULATOR_A3_GOOD_IN       (a3_good),
    .STEP_DOWN_GOOD_IN          (step_good),
    .REG_ADDR_IN                (addr),
    .REG_WDATA_IN               (wdata),
    .REG_WR_IN                  (wr),
    .REG_RD_IN                  (rd),
    .REG_RDATA_OUT              (rdata),
    .LOAD_SWITCH_A1_ENABLE_OUT  (en),
    .SWITCH_A1_THRESHOLD_OUT    (thr),
    .SWITCH_A1_THRESHOLD_MV_OUT (thr_mv),
    .TERMINATION_ENABLE_OUT     (term),
    .REGULATOR_A2_GOODS_OK_OUT  (a2ok)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // the longest delay sweep needs about 1300 cycles; leave ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic w3;
    repeat (3) @(negedge clk);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // counts rising edges until the enable reaches lvl, bounded
  task automatic measure(input logic lvl, output int n);
    n = 0;
    while (en !== lvl && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  function automatic logic in_tol(input int n, input int exp);
    return (n * 10 >= exp * 9) && (n * 10 <= exp * 11);
  endfunction

  task automatic test_regs;
    logic [7:0] d;
    logic [7:0] off [3] = '{SRC_CTRL_OFFSET, DLY_CTRL_OFFSET, A2_MASK_OFFSET};
    logic [7:0] rv [3] = '{SRC_CTRL_RESET, DLY_CTRL_RESET, A2_MASK_RESET};
    logic [7:0] wm [3] = '{SRC_CTRL_WMASK, DLY_CTRL_WMASK, A2_MASK_WMASK};
    for (int i = 0; i < 3; i++) begin
      reg_rd(off[i], d);
      `CHK(d, rv[i])
      reg_wr(off[i], 8'hff);
      reg_rd(off[i], d);
      `CHK(d, wm[i])
      reg_wr(off[i], 8'h00);
    end
    reg_wr(8'h1d, 8'h55);
    reg_rd(8'h1d, d);
    `CHK(d, 8'h00)
  endtask

  task automatic test_thr;
    logic [11:0] mv [4] = '{THR_1V5_MV, THR_1V8_MV, THR_2V5_MV, THR_3V3_MV};
    for (int c = 0; c < 4; c++) begin
      reg_wr(SRC_CTRL_OFFSET, {1'b0, 2'(c), 5'h1c});
      w3();
      `CHK(thr, 2'(c))
      `CHK(thr_mv, mv[c])
    end
  endtask

  task automatic test_src;
    int pin [8] = '{0, 1, 4, 3, 2, 0, 5, 0};
    reg_wr(DLY_CTRL_OFFSET, 8'h00);
    for (int c = 0; c < 8; c++) begin
      reg_wr(SRC_CTRL_OFFSET, {3'h0, 3'(c), 2'h3});
      if (c == 5) begin
        u_rsl_host_model.set_ctrl(6'h0c);
        w3();
        `CHK(en, 1'b1)
        u_rsl_host_model.set_ctrl(6'h04);
        w3();
        `CHK(en, 1'b0)
      end else if (c == 7) begin
        u_rsl_host_model.set_ctrl(6'h00);
        w3();
        `CHK(en, 1'b1)
      end else begin
        u_rsl_host_model.set_ctrl(6'(6'h01 << pin[c]));
        w3();
        `CHK(en, 1'b1)
        u_rsl_host_model.set_ctrl(~6'(6'h01 << pin[c]));
        w3();
        `CHK(en, 1'b0)
      end
    end
  endtask

  task automatic test_masks;
    reg_wr(SRC_CTRL_OFFSET, 8'h1c);
    u_rsl_host_model.set_goods(10'h37f);
    w3();
    `CHK(en, 1'b0)
    reg_wr(SRC_CTRL_OFFSET, 8'h1e);
    w3();
    `CHK(en, 1'b1)
    u_rsl_host_model.set_goods(10'h3bf);
    w3();
    `CHK(en, 1'b0)
    reg_wr(SRC_CTRL_OFFSET, 8'h1d);
    w3();
    `CHK(en, 1'b1)
    u_rsl_host_model.set_goods(10'h3ff);
  endtask

  task automatic test_term;
    for (int s = 0; s < 2; s++) begin
      reg_wr(DLY_CTRL_OFFSET, {1'b0, 1'(s), 6'h00});
      u_rsl_host_model.set_ctrl(s ? 6'h20 : 6'h04);
      w3();
      `CHK(term, 1'b1)
      u_rsl_host_model.set_ctrl(s ? 6'h04 : 6'h20);
      w3();
      `CHK(term, 1'b0)
    end
  endtask

  task automatic test_a2;
    logic [9:0] g;
    for (int b = 0; b < 8; b++) begin
      g = 10'h3ff;
      g[b == 7 ? 9 : (b == 6 ? 8 : b)] = 1'b0;
      u_rsl_host_model.set_goods(g);
      reg_wr(A2_MASK_OFFSET, 8'h00);
      w3();
      `CHK(a2ok, 1'b0)
      reg_wr(A2_MASK_OFFSET, 8'(8'h01 << b));
      w3();
      `CHK(a2ok, 1'b1)
    end
    u_rsl_host_model.set_goods(10'h3ff);
  endtask

  // the design is exact; the window allows the documented tolerance
  task automatic test_delay;
    int ms [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    int n;
    reg_wr(SRC_CTRL_OFFSET, 8'h03);
    u_rsl_host_model.set_ctrl(6'h00);
    for (int c = 0; c < 8; c++) begin
      reg_wr(DLY_CTRL_OFFSET, {2'h0, 3'(c), 3'(c)});
      w3();
      u_rsl_host_model.set_ctrl(6'h01);
      measure(1'b1, n);
      `CHK(in_tol(n, ms[c] * CYC + 1), 1'b1)
      u_rsl_host_model.set_ctrl(6'h00);
      measure(1'b0, n);
      `CHK(in_tol(n, ms[c] * CYC + 1), 1'b1)
    end
  endtask

  task automatic test_cancel;
    int n;
    reg_wr(DLY_CTRL_OFFSET, 8'h02);
    u_rsl_host_model.set_ctrl(6'h01);
    repeat (6) @(negedge clk);
    u_rsl_host_model.set_ctrl(6'h00);
    repeat (40) @(negedge clk);
    `CHK(en, 1'b0)
    u_rsl_host_model.set_ctrl(6'h01);
    measure(1'b1, n);
    `CHK(in_tol(n, 4 * CYC + 1), 1'b1)
  endtask

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    test_regs();
    test_thr();
    test_src();
    test_masks();
    test_term();
    test_a2();
    test_delay();
    test_cancel();
    close_out();
  end
endmodule // rsl_rail_enable_tb
`default_nettype wire
